// ---- rtl/rip_irq_power.sv ----
// Purpose: interrupt flags, enables, pin shaping and power state of an rtc
// Assumes: all inputs synchronous to clk_i; analog comparisons already resolved
// Notes:   registers on classic wishbone; a power-on-reset state holds them at reset values, oscillator fail flag set
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module rip_irq_power #(
  parameter int PULSE_W       = 8,
  parameter int ALARM_PULSE_1 = 16,
  parameter int ALARM_PULSE_2 = 64,
  parameter int ALARM_PULSE_3 = 255,
  parameter int TIMER_PULSE   = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire rip_pkg::rip_time_t time_now_i,
  input  wire rip_pkg::rip_time_t alarm_time_i,
  input  wire logic              countdown_zero_i,
  input  wire logic              watchdog_timeout_i,
  input  wire logic              battery_above_level_i,
  input  wire logic              ext_input_pin_i,
  input  wire logic              watchdog_input_pin_i,
  input  wire logic              osc_stopped_i,
  input  wire logic              autocal_failed_i,
  input  wire logic              main_present_i,
  input  wire logic              main_ok_i,
  input  wire logic              backup_ok_i,
  input  wire logic              backup_present_i,
  output logic                   interrupt_out_n_o,
  output logic                   countdown_irq_pin_n_o,
  output logic                   clock_out_irq_n_o,
  output logic                   watchdog_reset_o,
  output logic                   registers_reset_o,
  output logic                   use_rc_osc_o,
  output logic                   serial_enable_o,
  output rip_pkg::rip_pwr_t      power_state_o
);
  import rip_pkg::*;

  rip_pwr_t    pwr_ff;
  rip_status_t status_ff;
  rip_osc_t    osc_ff;
  rip_enable_t enable_ff;
  rip_ctrl_t   ctrl_ff;
  logic        soft_rst_ff;
  logic        prime_ff;
  logic        alarm_match_ff;
  logic        ext_one_eff_ff;
  logic        ext_two_eff_ff;
  logic        batt_level_ff;
  logic [PULSE_W-1:0] alarm_cnt_ff;
  logic [PULSE_W-1:0] timer_cnt_ff;

  logic        cfg_rst;
  logic        req;
  logic        bus_open;
  logic [5:0]  idx;
  logic        wr;
  logic        rd;
  logic        alarm_match;
  logic        ext_one_eff;
  logic        ext_two_eff;
  logic        alarm_evt;
  logic        countdown_evt;
  logic        watchdog_evt;
  logic        batt_evt;
  logic        ext_one_evt;
  logic        ext_two_evt;
  logic        alarm_term;
  logic        countdown_term;
  logic        irq_any;
  rip_pwr_t    nxt_pwr;
  rip_status_t nxt_status;
  rip_osc_t    nxt_osc;
  rip_status_t status_set;
  rip_status_t status_clr;
  rip_osc_t    osc_set;
  rip_osc_t    osc_clr;
  logic [31:0] rd_word;

  // pulse length for a shaping mode, zero meaning level form
  function automatic logic [PULSE_W-1:0] pulse_len(input logic [1:0] mode);
    case (mode)
      2'h1:    pulse_len = PULSE_W'(ALARM_PULSE_1);
      2'h2:    pulse_len = PULSE_W'(ALARM_PULSE_2);
      2'h3:    pulse_len = PULSE_W'(ALARM_PULSE_3);
      default: pulse_len = '0;
    endcase
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lane_merge = (old_w & ~m) | (new_w & m);
  endfunction

  // ---------------- power state ----------------
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_POR: begin
        // backup alone never leaves this state
        if (main_present_i) nxt_pwr = PWR_MAIN;
      end
      PWR_MAIN: begin
        if (!main_ok_i && backup_ok_i) nxt_pwr = PWR_BATTERY;
        else if (!main_present_i) nxt_pwr = PWR_POR;
      end
      PWR_BATTERY: begin
        if (!backup_present_i) nxt_pwr = PWR_POR;
        else if (main_ok_i) nxt_pwr = PWR_MAIN;
      end
      default: nxt_pwr = PWR_POR;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ff <= PWR_POR;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // registers held at reset values (oscillator fail flag set) while in power-on reset or after the key write
  assign cfg_rst = rst_i || soft_rst_ff || (pwr_ff == PWR_POR);

  // ---------------- wishbone slave ----------------
  // access takes effect at the edge that raises ack, so read data and
  // read-clear happen on the same edge and no event slips between them
  assign bus_open = serial_enable_o && (pwr_ff != PWR_POR);
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx      = wb_adr_i[7:2];
  assign wr       = req && wb_we_i && bus_open;
  assign rd       = req && !wb_we_i && bus_open;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_comb begin
    rd_word = '0;
    case (idx)
      IDX_STATUS:     rd_word[6:0] = status_ff;
      IDX_OSC_STATUS: rd_word[1:0] = osc_ff;
      IDX_INT_ENABLE: rd_word[7:0] = enable_ff;
      IDX_CONTROL:    rd_word      = ctrl_ff;
      IDX_PIN_STATUS: rd_word[6:0] = {serial_enable_o, use_rc_osc_o, pwr_ff,
                                      battery_above_level_i, watchdog_input_pin_i,
                                      ext_input_pin_i};
      default:        rd_word = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req) begin
      wb_dat_o <= rd ? rd_word : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr && (idx == IDX_CFG_KEY) && wb_sel_i[0] &&
                     (wb_dat_i[7:0] == KEY_SOFT_RESET);
    end
  end

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      enable_ff <= ENABLE_RST;
    end else if (wr && idx == IDX_INT_ENABLE && wb_sel_i[0]) begin
      enable_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr && idx == IDX_CONTROL) begin
      ctrl_ff <= lane_merge(ctrl_ff, wb_dat_i, wb_sel_i) & CTRL_WR_MASK;
    end
  end

  // ---------------- event detection ----------------
  always_comb begin
    case (ctrl_ff.alarm_repeat_select)
      RPT_YEAR:   alarm_match = (time_now_i[47:0] == alarm_time_i[47:0]);
      RPT_MONTH:  alarm_match = (time_now_i[39:0] == alarm_time_i[39:0]);
      RPT_WEEK:   alarm_match = (time_now_i.weekday == alarm_time_i.weekday) &&
                                (time_now_i[31:0] == alarm_time_i[31:0]);
      RPT_DAY:    alarm_match = (time_now_i[31:0] == alarm_time_i[31:0]);
      RPT_HOUR:   alarm_match = (time_now_i[23:0] == alarm_time_i[23:0]);
      RPT_MINUTE: alarm_match = (time_now_i[15:0] == alarm_time_i[15:0]);
      RPT_SECOND: alarm_match = (time_now_i.hundredths == alarm_time_i.hundredths);
      default:    alarm_match = 1'b0;
    endcase
  end

  // polarity folded in, so a select change alone can raise an edge
  assign ext_one_eff = ctrl_ff.ext_one_edge_select ? ext_input_pin_i : !ext_input_pin_i;
  assign ext_two_eff = ctrl_ff.ext_two_edge_select ? watchdog_input_pin_i
                                                   : !watchdog_input_pin_i;

  // previous-value registers; prime blocks a false edge just after reset
  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      prime_ff       <= 1'b0;
      alarm_match_ff <= 1'b0;
      ext_one_eff_ff <= 1'b0;
      ext_two_eff_ff <= 1'b0;
      batt_level_ff  <= 1'b0;
    end else begin
      prime_ff       <= 1'b1;
      alarm_match_ff <= alarm_match;
      ext_one_eff_ff <= ext_one_eff;
      ext_two_eff_ff <= ext_two_eff;
      batt_level_ff  <= battery_above_level_i;
    end
  end

  assign alarm_evt     = prime_ff && alarm_match && !alarm_match_ff;
  assign countdown_evt = countdown_zero_i && ctrl_ff.countdown_enable;
  assign watchdog_evt  = watchdog_timeout_i && (ctrl_ff.watchdog_period_field != '0);
  assign batt_evt      = prime_ff && (ctrl_ff.battery_edge_polarity ?
                         (battery_above_level_i && !batt_level_ff) :
                         (!battery_above_level_i && batt_level_ff));
  assign ext_one_evt   = prime_ff && ext_one_eff && !ext_one_eff_ff;
  assign ext_two_evt   = prime_ff && ext_two_eff && !ext_two_eff_ff;

  // ---------------- flags ----------------
  always_comb begin
    status_set = '0;
    status_set.alarm_flag        = alarm_evt;
    status_set.countdown_flag    = countdown_evt;
    status_set.watchdog_flag     = watchdog_evt;
    status_set.battery_low_flag  = batt_evt;
    status_set.ext_one_flag      = ext_one_evt;
    status_set.ext_two_flag      = ext_two_evt;
    status_set.backup_power_flag = (nxt_pwr == PWR_BATTERY) && (pwr_ff != PWR_BATTERY);
    status_clr = '0;
    if (wr && idx == IDX_STATUS && wb_sel_i[0]) begin
      status_clr = ~wb_dat_i[6:0];
    end else if (rd && idx == IDX_STATUS && enable_ff.read_clears_status) begin
      status_clr = '1;
    end
    // set wins, so an event on the clearing edge survives it
    nxt_status = (status_ff & ~status_clr) | status_set;
  end

  always_comb begin
    osc_set = '0;
    osc_set.osc_fail_flag     = osc_stopped_i;
    osc_set.autocal_fail_flag = autocal_failed_i;
    osc_clr = '0;
    // status reads leave these alone
    if (wr && idx == IDX_OSC_STATUS && wb_sel_i[0]) begin
      osc_clr = ~wb_dat_i[1:0];
    end
    nxt_osc = (osc_ff & ~osc_clr) | osc_set;
  end

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      osc_ff <= OSC_RST;
    end else begin
      osc_ff <= nxt_osc;
    end
  end

  // ---------------- pin shaping ----------------
  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      alarm_cnt_ff <= '0;
    end else if (alarm_evt) begin
      alarm_cnt_ff <= pulse_len(ctrl_ff.alarm_pulse_mode);
    end else if (alarm_cnt_ff != '0) begin
      alarm_cnt_ff <= alarm_cnt_ff - PULSE_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      timer_cnt_ff <= '0;
    end else if (countdown_evt && ctrl_ff.countdown_pulse_mode) begin
      timer_cnt_ff <= PULSE_W'(TIMER_PULSE);
    end else if (timer_cnt_ff != '0) begin
      timer_cnt_ff <= timer_cnt_ff - PULSE_W'(1);
    end
  end

  always_comb begin
    if (ctrl_ff.alarm_pulse_mode == PULSE_LEVEL) begin
      alarm_term = status_ff.alarm_flag;
    end else begin
      alarm_term = (alarm_cnt_ff != '0);
    end
    alarm_term = alarm_term && enable_ff.alarm_irq_enable;
    if (ctrl_ff.countdown_pulse_mode) begin
      countdown_term = (timer_cnt_ff != '0);
    end else begin
      countdown_term = status_ff.countdown_flag;
    end
    countdown_term = countdown_term && enable_ff.countdown_irq_enable;
  end

  // level-only sources stay asserted until their flag is cleared
  assign irq_any = alarm_term || countdown_term ||
                   (status_ff.watchdog_flag && !ctrl_ff.watchdog_steer) ||
                   (status_ff.battery_low_flag && enable_ff.battery_low_irq_enable) ||
                   (status_ff.ext_one_flag && enable_ff.ext_one_irq_enable) ||
                   (status_ff.ext_two_flag && enable_ff.ext_two_irq_enable) ||
                   (osc_ff.osc_fail_flag && enable_ff.osc_fail_irq_enable) ||
                   (osc_ff.autocal_fail_flag && enable_ff.autocal_fail_irq_enable);

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      interrupt_out_n_o     <= 1'b1;
      countdown_irq_pin_n_o <= 1'b1;
      clock_out_irq_n_o     <= 1'b1;
    end else begin
      interrupt_out_n_o     <= !irq_any;
      countdown_irq_pin_n_o <= !countdown_term;
      clock_out_irq_n_o     <= !(countdown_term &&
                                 ctrl_ff.square_wave_select == SQ_SEL_COUNTDOWN);
    end
  end

  // reset request is a one-cycle pulse per watchdog timeout
  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      watchdog_reset_o <= 1'b0;
    end else begin
      watchdog_reset_o <= watchdog_evt && ctrl_ff.watchdog_steer;
    end
  end

  // ---------------- power outputs ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      registers_reset_o <= 1'b1;
      use_rc_osc_o      <= 1'b0;
      serial_enable_o   <= 1'b0;
      power_state_o     <= PWR_POR;
    end else begin
      registers_reset_o <= (nxt_pwr == PWR_POR) || soft_rst_ff;
      use_rc_osc_o      <= (nxt_pwr == PWR_BATTERY) && ctrl_ff.auto_rc_on_battery;
      // closed in power-on reset too, not only on battery without the enable
      serial_enable_o   <= (nxt_pwr == PWR_MAIN) ||
                           ((nxt_pwr == PWR_BATTERY) && ctrl_ff.serial_on_battery_enable);
      power_state_o     <= nxt_pwr;
    end
  end

endmodule

// ---- rtl/rip_pkg.sv ----
// Purpose: shared constants and carriers for the rtc interrupt and power status block
// Assumes: 32-bit classic wishbone, register index times four gives the byte address
// Notes:   flag layouts follow the order of the status and oscillator status registers
package rip_pkg;

  // register indices; byte address is the index times four
  localparam logic [5:0] IDX_STATUS     = 6'h0F;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h12;
  localparam logic [5:0] IDX_CONTROL    = 6'h18;
  localparam logic [5:0] IDX_OSC_STATUS = 6'h1D;
  localparam logic [5:0] IDX_CFG_KEY    = 6'h1F;
  localparam logic [5:0] IDX_PIN_STATUS = 6'h2F;

  localparam logic [7:0] KEY_SOFT_RESET = 8'h3C;

  // square wave select code that routes the countdown interrupt to the clock pin
  localparam logic [3:0] SQ_SEL_COUNTDOWN = 4'h3;

  // alarm repeat select codes
  localparam logic [2:0] RPT_OFF    = 3'h0;
  localparam logic [2:0] RPT_YEAR   = 3'h1;
  localparam logic [2:0] RPT_MONTH  = 3'h2;
  localparam logic [2:0] RPT_WEEK   = 3'h3;
  localparam logic [2:0] RPT_DAY    = 3'h4;
  localparam logic [2:0] RPT_HOUR   = 3'h5;
  localparam logic [2:0] RPT_MINUTE = 3'h6;
  localparam logic [2:0] RPT_SECOND = 3'h7;

  localparam logic [1:0] PULSE_LEVEL = 2'h0;

  typedef enum logic [1:0] {
    PWR_POR     = 2'b00,
    PWR_MAIN    = 2'b01,
    PWR_BATTERY = 2'b10
  } rip_pwr_t;

  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] hundredths;
  } rip_time_t;

  typedef struct packed {
    logic backup_power_flag;
    logic ext_two_flag;
    logic ext_one_flag;
    logic battery_low_flag;
    logic watchdog_flag;
    logic countdown_flag;
    logic alarm_flag;
  } rip_status_t;

  typedef struct packed {
    logic autocal_fail_flag;
    logic osc_fail_flag;
  } rip_osc_t;

  typedef struct packed {
    logic read_clears_status;
    logic autocal_fail_irq_enable;
    logic osc_fail_irq_enable;
    logic ext_two_irq_enable;
    logic ext_one_irq_enable;
    logic battery_low_irq_enable;
    logic countdown_irq_enable;
    logic alarm_irq_enable;
  } rip_enable_t;

  typedef struct packed {
    logic [9:0] reserved;
    logic [2:0] alarm_repeat_select;
    logic       serial_on_battery_enable;
    logic       auto_rc_on_battery;
    logic       battery_edge_polarity;
    logic       ext_two_edge_select;
    logic       ext_one_edge_select;
    logic [4:0] watchdog_period_field;
    logic       watchdog_steer;
    logic [3:0] square_wave_select;
    logic       countdown_enable;
    logic       countdown_pulse_mode;
    logic [1:0] alarm_pulse_mode;
  } rip_ctrl_t;

  localparam rip_status_t STATUS_RST = 7'h00;
  localparam rip_osc_t    OSC_RST    = 2'h1;
  localparam rip_enable_t ENABLE_RST = 8'h00;
  localparam rip_ctrl_t   CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL_WR_MASK = 32'h003F_FFFF;

endpackage

// ---- testbench/rip_host.sv ----
// Purpose: host controller model on the classic wishbone register bus
// Assumes: slave acks each request; the bench watchdog ends a hang
// Notes:   idle lines show inverted last values so stale data is never read as valid
`timescale 1ns/100ps
module rip_host (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  // one access; cyc stays low for a cycle before the next one
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    r = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= ~w;
    wb_adr_o <= ~a;
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~d;
  endtask
endmodule

// ---- testbench/rip_irq_power_chk.sv ----
// Purpose: port-level checks for the rtc interrupt and power status block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   register contents are invisible here, so only bus, power, watchdog reset and interrupt pin relations
`timescale 1ns/100ps
module rip_irq_power_chk
  import rip_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        main_present_i,
  input wire logic        main_ok_i,
  input wire logic        backup_ok_i,
  input wire logic        backup_present_i,
  input wire logic        watchdog_timeout_i,
  input wire logic        watchdog_reset_o,
  input wire logic        interrupt_out_n_o,
  input wire logic        countdown_irq_pin_n_o,
  input wire logic        serial_enable_o,
  input wire logic        registers_reset_o,
  input wire rip_pwr_t    power_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_por_holds_regs: assert property (
    power_state_o == PWR_POR && !main_present_i |=> power_state_o == PWR_POR && registers_reset_o)
    else $error("power-on state left or registers released without main supply");
  a_main_to_battery: assert property (
    power_state_o == PWR_MAIN && main_present_i && !main_ok_i && backup_ok_i
    |=> power_state_o == PWR_BATTERY) else $error("no switch to battery");
  a_main_stays_main: assert property (
    power_state_o == PWR_MAIN && main_ok_i |=> power_state_o == PWR_MAIN)
    else $error("left main state with main supply good");
  a_battery_to_por: assert property (
    power_state_o == PWR_BATTERY && !backup_present_i |=> power_state_o == PWR_POR)
    else $error("backup loss did not reset");
  a_battery_to_main: assert property (
    power_state_o == PWR_BATTERY && backup_present_i && main_ok_i |=> power_state_o == PWR_MAIN)
    else $error("no return to main state");
  a_wdog_reset_cause: assert property (
    watchdog_reset_o |-> $past(watchdog_timeout_i)) else $error("watchdog reset without timeout");
  a_wdog_reset_pulse: assert property (
    watchdog_reset_o && !watchdog_timeout_i |=> !watchdog_reset_o)
    else $error("watchdog reset longer than one cycle");
  a_por_irq_quiet: assert property (
    (power_state_o == PWR_POR) [*3] |-> interrupt_out_n_o && countdown_irq_pin_n_o)
    else $error("interrupt asserted in power-on state");
  a_por_read_zero: assert property (
    power_state_o == PWR_POR && wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o && wb_dat_o == 32'h0000_0000) else $error("read in power-on state not zero");
  a_por_serial_off: assert property (
    power_state_o == PWR_POR |-> !serial_enable_o) else $error("serial enabled in power-on state");
endmodule

bind rip_irq_power rip_irq_power_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_dat_o, .main_present_i, .main_ok_i, .backup_ok_i, .backup_present_i, .watchdog_timeout_i,
  .watchdog_reset_o, .interrupt_out_n_o, .countdown_irq_pin_n_o, .serial_enable_o,
  .registers_reset_o, .power_state_o);

// ---- testbench/rip_irq_power_test.sv ----
// Purpose: directed bench for the rtc interrupt and power status block
// Assumes: host model drives the bus; other inputs change on rising edges
// Notes:   flags are seen through status reads, outputs sampled after settling
`timescale 1ns/100ps
module rip_irq_power_test
  import rip_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r;
  logic        cd_zero = 1'b0, wd_tmo = 1'b0, bat_above = 1'b1, ext_pin = 1'b0;
  logic        osc_stop = 1'b0, mp = 1'b0, mok = 1'b1, bok = 1'b0, bpr = 1'b0;
  logic        wd_pin = 1'b0, acal = 1'b0, wd_rst, rc_osc;
  logic        irq_n, cd_pin_n, clk_pin_n, serial_en, regs_rst;
  rip_pwr_t    pwr;
  rip_time_t   tnow = '0;
  rip_time_t   talm = 56'h01_02_03_04_05_06_07;
  rip_ctrl_t   ctl = CTRL_RST;
  int          n_errors = 0;
  int          comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  rip_host host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(dat_r), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w));

  rip_irq_power uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .time_now_i(tnow), .alarm_time_i(talm), .countdown_zero_i(cd_zero),
    .watchdog_timeout_i(wd_tmo), .battery_above_level_i(bat_above), .ext_input_pin_i(ext_pin),
    .watchdog_input_pin_i(wd_pin), .osc_stopped_i(osc_stop), .autocal_failed_i(acal),
    .main_present_i(mp), .main_ok_i(mok), .backup_ok_i(bok), .backup_present_i(bpr),
    .interrupt_out_n_o(irq_n), .countdown_irq_pin_n_o(cd_pin_n), .clock_out_irq_n_o(clk_pin_n),
    .watchdog_reset_o(wd_rst), .registers_reset_o(regs_rst), .use_rc_osc_o(rc_osc),
    .serial_enable_o(serial_en), .power_state_o(pwr));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0000_0000, r);
    chk(nm, exp, r);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    tick(20);
    rst_i <= 1'b0;
    tick(2);
    rd("por status", 8'h3C, 32'h0000_0000);
    mp <= 1'b1;
    tick(3);
    rd("osc reset", 8'h74, 32'h0000_0001);
    ctl.countdown_enable = 1'b1;
    wr(8'h60, ctl);
    cd_zero <= 1'b1;
    tick(1);
    cd_zero <= 1'b0;
    tick(3);
    chkb("irq masked", 1'b1, irq_n);
    rd("cd flag", 8'h3C, 32'h0000_0002);
    wr(8'h48, 32'h0000_0002);
    tick(2);
    chkb("irq on", 1'b0, irq_n);
    chkb("cd pin", 1'b0, cd_pin_n);
    chkb("clk pin off", 1'b1, clk_pin_n);
    ctl.square_wave_select = SQ_SEL_COUNTDOWN;
    wr(8'h60, ctl);
    tick(2);
    chkb("clk pin", 1'b0, clk_pin_n);
    ctl.countdown_pulse_mode = 1'b1;
    wr(8'h60, ctl);
    cd_zero <= 1'b1;
    tick(1);
    cd_zero <= 1'b0;
    tick(3);
    chkb("cd pulse on", 1'b0, cd_pin_n);
    tick(16);
    chkb("cd pulse off", 1'b1, cd_pin_n);
    ctl.countdown_pulse_mode = 1'b0;
    wr(8'h60, ctl);
    wr(8'h3C, 32'h0000_007D);
    tick(2);
    chkb("irq cleared", 1'b1, irq_n);
    // watchdog timeout sets its flag only with a nonzero period
    for (int p = 0; p < 2; p++) begin
      ctl.watchdog_period_field = p[4:0];
      wr(8'h60, ctl);
      wd_tmo <= 1'b1;
      tick(1);
      wd_tmo <= 1'b0;
      @(negedge clk_i);
      chkb("wd reset off", 1'b0, wd_rst);
      tick(3);
      chkb("wd irq", p[0] ? 1'b0 : 1'b1, irq_n);
    end
    wr(8'h48, 32'h0000_0080);
    rd("clear read", 8'h3C, 32'h0000_0004);
    rd("reread", 8'h3C, 32'h0000_0000);
    rd("osc kept", 8'h74, 32'h0000_0001);
    ctl.watchdog_steer = 1'b1;
    ctl.ext_one_edge_select = 1'b1;
    wr(8'h60, ctl);
    wd_tmo <= 1'b1;
    tick(1);
    wd_tmo <= 1'b0;
    @(negedge clk_i);
    chkb("wd reset", 1'b1, wd_rst);
    tick(3);
    chkb("wd steered", 1'b1, irq_n);
    wr(8'h3C, 32'h0000_0000);
    ext_pin <= 1'b1;
    tick(4);
    rd("ext flag", 8'h3C, 32'h0000_0010);
    wd_pin <= 1'b1;
    tick(2);
    wd_pin <= 1'b0;
    tick(4);
    rd("ext two flag", 8'h3C, 32'h0000_0020);
    rd("pins", 8'hBC, 32'h0000_004D);
    tnow <= talm ^ 56'h00_00_00_00_01_00_00;
    ctl.alarm_repeat_select = RPT_HOUR;
    wr(8'h60, ctl);
    tick(3);
    rd("alarm hour", 8'h3C, 32'h0000_0000);
    ctl.alarm_repeat_select = RPT_SECOND;
    ctl.alarm_pulse_mode    = 2'h1;
    wr(8'h48, 32'h0000_0001);
    wr(8'h60, ctl);
    tick(3);
    chkb("alarm pulse", 1'b0, irq_n);
    rd("alarm second", 8'h3C, 32'h0000_0001);
    tick(16);
    chkb("alarm pulse end", 1'b1, irq_n);
    bat_above <= 1'b0;
    tick(4);
    rd("battery low", 8'h3C, 32'h0000_0009);
    wr(8'h74, 32'h0000_0000);
    rd("osc cleared", 8'h74, 32'h0000_0000);
    wr(8'h48, 32'h0000_0020);
    osc_stop <= 1'b1;
    tick(1);
    osc_stop <= 1'b0;
    tick(3);
    chkb("osc irq", 1'b0, irq_n);
    acal <= 1'b1;
    tick(1);
    acal <= 1'b0;
    rd("acal flag", 8'h74, 32'h0000_0003);
    wr(8'h48, 32'h0000_0040);
    tick(2);
    chkb("acal irq", 1'b0, irq_n);
    wr(8'h74, 32'h0000_0001);
    tick(2);
    chkb("acal cleared", 1'b1, irq_n);
    wr(8'h7C, {24'h0, KEY_SOFT_RESET});
    rd("soft reset", 8'h48, 32'h0000_0000);
    rd("osc after reset", 8'h74, 32'h0000_0001);
    ctl = CTRL_RST;
    ctl.auto_rc_on_battery = 1'b1;
    wr(8'h60, ctl);
    mok <= 1'b0;
    bok <= 1'b1;
    bpr <= 1'b1;
    tick(3);
    chk("battery state", 32'(PWR_BATTERY), 32'(pwr));
    chkb("rc osc", 1'b1, rc_osc);
    rd("bus closed", 8'hBC, 32'h0000_0000);
    mok <= 1'b1;
    tick(3);
    rd("backup flag", 8'h3C, 32'h0000_0040);
    mok <= 1'b0;
    tick(3);
    mp  <= 1'b0;
    bpr <= 1'b0;
    tick(3);
    chk("por again", 32'(PWR_POR), 32'(pwr));
    chkb("regs held", 1'b1, regs_rst);
    chkb("serial off", 1'b0, serial_en);
    report_and_stop();
  end
endmodule
